// ### src/wfifo_defines.svh
// Purpose: Constants for the write side of a dual-clock word queue.
// Assumes: Included by bare name; definitions only.
// Notes: Types live in wfifo_pkg.
//
// Function
// - Core reset clears all logic in write and read domains.
// - Core reset is asynchronous and synchronised in each domain before use.
// - Core reset returns all pointers and output registers to initial state.
// - While sleep is held, the block stays in power-saving mode.
// - All write-side signals are sampled or updated on the write clock edge.
// - Write request when not full and not sleeping stores the input word.
// - While full, write requests are ignored and nothing is stored.
// - A write while full leaves stored words and pointers unchanged.
// - Write-domain reset reinitialises write-domain pointers and flags only.
// - Almost-full asserts when exactly one more word fits.
// - High-water flag asserts when count reaches the assert threshold.
// - High-water flag clears when count drops below the negate threshold.
// - Overflow pulses one cycle after a rejected write.
// - Write acknowledge pulses one cycle after a successful write.
// - Write fill count lags the write pointer by one cycle and can under-report; a write shows two edges later.
`ifndef WFIFO_DEFINES_SVH
`define WFIFO_DEFINES_SVH
`define WF_DEPTH 16
`define WF_ADDR_W 4
`define WF_DATA_W 8
`define WF_STAGE_DEPTH 8
`define WF_SYNC_STAGES 2
`endif

// ### src/wfifo_pkg.sv
// Purpose: Types for the write side of a dual-clock word queue.
// Assumes: Nothing beyond the constants header.
// Notes: State enum for reset sequencing.
package wfifo_pkg;
    typedef enum logic [1:0] {RST_HOLD, RST_RUN} rst_state_type;
endpackage

// ### src/stage_fifo.sv
// Purpose: Small synchronous valid/ready FIFO in the write data path.
// Assumes: Single clock, synchronous active-high clear.
// Notes: Depth must be a power of two.
`timescale 1ns/100ps
`default_nettype none
module stage_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    // Clock and clear
    input wire logic core_clk_i,
    input wire logic clear_i,
    // Fill side
    input wire logic in_valid_i,
    input wire logic [WIDTH-1:0] in_data_i,
    output logic in_ready_o,
    // Drain side
    output logic out_valid_o,
    output logic [WIDTH-1:0] out_data_o,
    input wire logic out_ready_i
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0] wp;
    logic [AW:0] rp;
    wire push = in_valid_i && in_ready_o;
    wire pop = out_valid_o && out_ready_i;
    wire is_full = (wp[AW] != rp[AW]) && (wp[AW-1:0] == rp[AW-1:0]);
    assign in_ready_o = !is_full;
    assign out_valid_o = (wp != rp);
    assign out_data_o = mem[rp[AW-1:0]];
    always_ff @(posedge core_clk_i) begin
        if (clear_i) begin
            wp <= '0;
            rp <= '0;
        end else begin
            if (push) begin
                wp <= wp + 1'b1;
            end
            if (pop) begin
                rp <= rp + 1'b1;
            end
        end
    end
    always_ff @(posedge core_clk_i) begin
        if (push) begin
            mem[wp[AW-1:0]] <= in_data_i;
        end
    end
endmodule
`default_nettype wire

// ### src/wfifo_write_side.sv
// Purpose: Write-side control of a dual-clock word queue with status flags.
// Assumes: Producer inputs are synchronous to core_clk_i; read pointer arrives gray-coded.
// Notes: Storage is external; this block drives the write strobe, address and data.
`timescale 1ns/100ps
`default_nettype none
`include "wfifo_defines.svh"
module wfifo_write_side
    import wfifo_pkg::*;
#(
    parameter int DATA_W = `WF_DATA_W,
    parameter int ADDR_W = `WF_ADDR_W,
    parameter int STAGE_DEPTH = `WF_STAGE_DEPTH
) (
    // Clock, resets and sleep
    input wire logic core_clk_i,
    input wire logic srst_i,
    input wire logic core_rst_async_i,
    input wire logic wr_rst_i,
    input wire logic sleep_i,
    // Producer stream
    input wire logic wr_req_i,
    input wire logic [DATA_W-1:0] wr_data_i,
    output logic stage_ready_o,
    // Thresholds
    input wire logic [ADDR_W:0] hw_assert_i,
    input wire logic [ADDR_W:0] hw_negate_i,
    // Status
    output logic full_o,
    output logic almost_full_o,
    output logic high_water_o,
    output logic wr_ack_o,
    output logic overflow_o,
    output logic [ADDR_W:0] wr_count_o,
    output logic sleeping_o,
    output logic rst_busy_o,
    // Storage and read-side crossing
    output logic mem_we_o,
    output logic [ADDR_W-1:0] mem_addr_o,
    output logic [DATA_W-1:0] mem_data_o,
    output logic [ADDR_W:0] wr_ptr_gray_o,
    output logic rd_rst_o,
    input wire logic [ADDR_W:0] rd_ptr_gray_i
);
    localparam logic [ADDR_W:0] CAP = (ADDR_W+1)'(1 << ADDR_W);

    // Core reset synchroniser; the first stage feeds only the second.
    logic rs1;
    logic rs2;
    logic core_rst;
    always_ff @(posedge core_clk_i or posedge core_rst_async_i) begin
        if (core_rst_async_i) begin
            rs1 <= 1'b1;
            rs2 <= 1'b1;
        end else begin
            rs1 <= 1'b0;
            rs2 <= rs1;
        end
    end
    assign core_rst = rs2 || srst_i;
    wire dom_rst = core_rst || wr_rst_i;

    // Read pointer crossing.
    logic [ADDR_W:0] rg1;
    logic [ADDR_W:0] rg2;
    always_ff @(posedge core_clk_i) begin
        if (dom_rst) begin
            rg1 <= '0;
            rg2 <= '0;
        end else begin
            rg1 <= rd_ptr_gray_i;
            rg2 <= rg1;
        end
    end
    function automatic logic [ADDR_W:0] g2b(input logic [ADDR_W:0] g);
        logic [ADDR_W:0] b;
        b = '0;
        for (int i = ADDR_W; i >= 0; i--) begin
            b[i] = (i == ADDR_W) ? g[i] : (b[i+1] ^ g[i]);
        end
        return b;
    endfunction
    wire [ADDR_W:0] rd_bin = g2b(rg2);

    // Front staging FIFO; held back while sleeping so the path stays quiet.
    logic st_valid;
    logic [DATA_W-1:0] st_data;
    logic st_ready;
    logic in_ready;
    stage_fifo #(.WIDTH(DATA_W), .DEPTH(STAGE_DEPTH)) u_stage (
        .core_clk_i(core_clk_i),
        .clear_i(dom_rst),
        .in_valid_i(wr_req_i && !sleeping_o),
        .in_data_i(wr_data_i),
        .in_ready_o(in_ready),
        .out_valid_o(st_valid),
        .out_data_o(st_data),
        .out_ready_i(st_ready)
    );

    logic [ADDR_W:0] wp;
    wire [ADDR_W:0] used = wp - rd_bin;
    wire at_cap = (used == CAP);
    wire accept = st_valid && !full_o && !sleeping_o;
    wire reject = st_valid && full_o && !sleeping_o;
    assign st_ready = accept || reject;
    wire [ADDR_W:0] next_wp = accept ? wp + 1'b1 : wp;
    wire [ADDR_W:0] next_used = next_wp - rd_bin;
    wire [ADDR_W:0] next_gray = next_wp ^ (next_wp >> 1);

    // Threshold capture during reset.
    logic [ADDR_W:0] th_on;
    logic [ADDR_W:0] th_off;
    rst_state_type rst_state;
    always_ff @(posedge core_clk_i) begin
        if (core_rst) begin
            rst_state <= RST_HOLD;
            th_on <= hw_assert_i;
            th_off <= hw_negate_i;
        end else begin
            case (rst_state)
                RST_HOLD: rst_state <= RST_RUN;
                default: rst_state <= RST_RUN;
            endcase
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (dom_rst) begin
            wp <= '0;
            wr_ptr_gray_o <= '0;
            full_o <= 1'b0;
            almost_full_o <= 1'b0;
            high_water_o <= 1'b0;
            wr_ack_o <= 1'b0;
            overflow_o <= 1'b0;
            wr_count_o <= '0;
            mem_we_o <= 1'b0;
            mem_addr_o <= '0;
            mem_data_o <= '0;
        end else begin
            wp <= next_wp;
            wr_ptr_gray_o <= next_gray;
            full_o <= (next_used == CAP);
            almost_full_o <= (next_used == CAP - 1'b1);
            if (next_used >= th_on) begin
                high_water_o <= 1'b1;
            end else if (next_used < th_off) begin
                high_water_o <= 1'b0;
            end
            wr_ack_o <= accept;
            overflow_o <= reject;
            wr_count_o <= used;
            mem_we_o <= accept;
            mem_addr_o <= wp[ADDR_W-1:0];
            mem_data_o <= st_data;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (core_rst) begin
            sleeping_o <= 1'b0;
            rst_busy_o <= 1'b1;
            rd_rst_o <= 1'b1;
            stage_ready_o <= 1'b0;
        end else begin
            sleeping_o <= sleep_i;
            rst_busy_o <= (rst_state == RST_HOLD);
            rd_rst_o <= 1'b0;
            stage_ready_o <= in_ready && !sleep_i && !wr_rst_i;
        end
    end

    property p_ack;
        @(posedge core_clk_i) disable iff (dom_rst) accept |=> wr_ack_o;
    endproperty
    a_ack: assert property (p_ack) else $error("ack missing");
    property p_ovf;
        @(posedge core_clk_i) disable iff (dom_rst) reject |=> overflow_o && !wr_ack_o;
    endproperty
    a_ovf: assert property (p_ovf) else $error("overflow missing");
    property p_nofull_write;
        @(posedge core_clk_i) disable iff (dom_rst) full_o |-> !accept;
    endproperty
    a_nofull_write: assert property (p_nofull_write) else $error("write while full");
    property p_ptr_hold;
        @(posedge core_clk_i) disable iff (dom_rst) (st_valid && full_o) |=> $stable(wp);
    endproperty
    a_ptr_hold: assert property (p_ptr_hold) else $error("pointer moved on overflow");
    property p_store;
        @(posedge core_clk_i) disable iff (dom_rst) accept |=> mem_we_o && mem_data_o == $past(st_data);
    endproperty
    a_store: assert property (p_store) else $error("word not stored");
    property p_full;
        @(posedge core_clk_i) disable iff (dom_rst) full_o |-> (wp - $past(rd_bin)) == CAP;
    endproperty
    a_full: assert property (p_full) else $error("full without capacity");
    property p_af;
        @(posedge core_clk_i) disable iff (dom_rst) almost_full_o |-> !full_o;
    endproperty
    a_af: assert property (p_af) else $error("almost full with full");
    property p_hw;
        @(posedge core_clk_i) disable iff (dom_rst) (!high_water_o ##1 high_water_o) |-> (wp - $past(rd_bin)) >= th_on;
    endproperty
    a_hw: assert property (p_hw) else $error("high water early");
    property p_rst;
        @(posedge core_clk_i) wr_rst_i |=> wp == '0 && !full_o && !wr_ack_o;
    endproperty
    a_rst: assert property (p_rst) else $error("write reset ineffective");
endmodule
`default_nettype wire

// ### verif/producer_model.sv
// Purpose: Producer logic on the write side of the word queue.
// Assumes: Requests change only on the falling edge of core_clk_i.
// Notes: Idle data shows the inverse of the last word, so a stale word is never mistaken for a live one.
`timescale 1ns/100ps
`default_nettype none
module producer_model #(
    parameter int DATA_W = 8
) (
    // Clock
    input wire logic core_clk_i,
    // Stream
    output logic wr_req_o,
    output logic [DATA_W-1:0] wr_data_o,
    // Thresholds
    output logic [4:0] hw_assert_o,
    output logic [4:0] hw_negate_o
);
    // Levels are fixed from time zero, so they are settled during every reset.
    assign hw_assert_o = 5'h0C;
    assign hw_negate_o = 5'h0A;
    initial begin
        wr_req_o = 1'b0;
        wr_data_o = '0;
    end
    task automatic push(input logic [DATA_W-1:0] word);
        @(negedge core_clk_i);
        wr_req_o = 1'b1;
        wr_data_o = word;
        @(negedge core_clk_i);
        wr_req_o = 1'b0;
        wr_data_o = ~word;
    endtask
endmodule
`default_nettype wire

// ### verif/tb_top.sv
// Purpose: Self-checking bench for the write side of the word queue.
// Assumes: No reads happen except through the read pointer driven here.
// Notes: Depth 16, thresholds 12 and 10.
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    logic core_clk_i, srst_i, core_rst_async_i, wr_rst_i, sleep_i, wr_req, stage_ready;
    logic full, almost_full, high_water, wr_ack, overflow, sleeping, rst_busy, mem_we, rd_rst;
    logic [7:0] wr_data, mem_data;
    logic [4:0] hw_assert, hw_negate, wr_count, wr_ptr_gray, rd_ptr_gray;
    logic [3:0] mem_addr;
    int fails = 0;
    int tests_run = 0;
    initial begin
        core_clk_i = 1'b0;
        forever #2.5 core_clk_i = ~core_clk_i;
    end
    producer_model #(.DATA_W(8)) prod (.core_clk_i(core_clk_i), .wr_req_o(wr_req), .wr_data_o(wr_data),
        .hw_assert_o(hw_assert), .hw_negate_o(hw_negate));
    wfifo_write_side #(.DATA_W(8), .ADDR_W(4), .STAGE_DEPTH(8)) dut (.core_clk_i(core_clk_i),
        .srst_i(srst_i), .core_rst_async_i(core_rst_async_i), .wr_rst_i(wr_rst_i), .sleep_i(sleep_i),
        .wr_req_i(wr_req), .wr_data_i(wr_data), .stage_ready_o(stage_ready), .hw_assert_i(hw_assert),
        .hw_negate_i(hw_negate), .full_o(full), .almost_full_o(almost_full), .high_water_o(high_water),
        .wr_ack_o(wr_ack), .overflow_o(overflow), .wr_count_o(wr_count), .sleeping_o(sleeping),
        .rst_busy_o(rst_busy), .mem_we_o(mem_we), .mem_addr_o(mem_addr), .mem_data_o(mem_data),
        .wr_ptr_gray_o(wr_ptr_gray), .rd_rst_o(rd_rst), .rd_ptr_gray_i(rd_ptr_gray));
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp) begin
            fails++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic report_and_stop;
        $display("comparisons %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // The answer is sampled at the falling edge so that the one-cycle pulse is fully settled.
    task automatic write_word(input logic [7:0] w, input logic ok, input logic [3:0] a);
        prod.push(w);
        repeat (8) if (!(wr_ack === 1'b1 || overflow === 1'b1)) @(negedge core_clk_i);
        check({wr_ack, overflow, mem_we}, ok ? 3'b101 : 3'b010);
        if (ok)
            check({mem_addr, mem_data}, {a, w});
    endtask
    initial begin
        #50000;
        fails++;
        report_and_stop;
    end
    initial begin
        {core_rst_async_i, wr_rst_i, sleep_i} = 3'h0;
        rd_ptr_gray = 5'h00;
        srst_i = 1'b1;
        repeat (16) @(negedge core_clk_i);
        srst_i = 1'b0;
        repeat (40) if (rst_busy !== 1'b0) @(negedge core_clk_i);
        repeat (2) @(negedge core_clk_i);
        check({full, wr_ack, overflow, wr_count}, 16'h0000);
        sleep_i = 1'b1;
        repeat (4) @(negedge core_clk_i);
        check({sleeping, stage_ready}, 2'b10);
        prod.push(8'h5A);
        repeat (8) @(negedge core_clk_i);
        check(wr_count, 5'h00);
        sleep_i = 1'b0;
        repeat (4) @(negedge core_clk_i);
        check({sleeping, stage_ready}, 2'b01);
        for (int n = 1; n <= 16; n++) begin
            write_word(8'(n * 17), 1'b1, 4'(n - 1));
            @(negedge core_clk_i);
            check({wr_count, full, almost_full, high_water}, {5'(n), n == 16, n == 15, n >= 12});
        end
        write_word(8'hEE, 1'b0, 4'h0);
        @(negedge core_clk_i);
        check({wr_count, full, wr_ptr_gray}, {5'h10, 1'b1, 5'h18});
        rd_ptr_gray = 5'h05;
        repeat (20) if (wr_count !== 5'h0A) @(negedge core_clk_i);
        check({wr_count, full, almost_full, high_water}, {5'h0A, 3'b001});
        rd_ptr_gray = 5'h04;
        repeat (20) if (wr_count !== 5'h09) @(negedge core_clk_i);
        check({wr_count, high_water}, {5'h09, 1'b0});
        write_word(8'h3C, 1'b1, 4'h0);
        wr_rst_i = 1'b1;
        rd_ptr_gray = 5'h00;
        repeat (3) @(negedge core_clk_i);
        wr_rst_i = 1'b0;
        repeat (40) if (rst_busy !== 1'b0) @(negedge core_clk_i);
        repeat (2) @(negedge core_clk_i);
        check({wr_count, full, high_water}, 16'h0000);
        write_word(8'hA5, 1'b1, 4'h0);
        core_rst_async_i = 1'b1;
        repeat (6) @(negedge core_clk_i);
        check({rd_rst, rst_busy, wr_count}, {2'b11, 5'h00});
        core_rst_async_i = 1'b0;
        repeat (40) if (rst_busy !== 1'b0) @(negedge core_clk_i);
        check({rd_rst, full, wr_count}, 16'h0000);
        report_and_stop;
    end
endmodule
`default_nettype wire
